/* rtl/dmr_mode_regs.v */
// Mode register group for termination, oscillator run time, activation report and repair status.
// Assumes a decoded mode-register command port on the DRAM clock and a pad input from outside.
//
// Notes on behaviour
// - Controller termination field: off, divisor one-six, reserved.
// - Clock override terminates clock regardless of pad, given a valid value.
// - Chip-select override terminates chip select regardless of pad, given a valid value.
// - Command termination: pad high, valid value, not disabled.
// - Writes and reads reach write-selected set point.
// - Behaviour follows operating set point copy only.
// - Termination persists in every power state.
// - Runtime codes 1-63 stop after code times 16.
// - Long codes stop after 2048, 4096, 8192 clocks.
// - Zero runtime: run until stop command.
// - Activation count field reports strapped code.
// - Unlimited bit forces activation count field zero.
// - Targeted refresh bank number and enable, off.
// - Repair bits, one per bank, one means available.
// - Oscillator count read as low, high bytes.
`timescale 1ns/1ps
`include "dmr_consts.vh"
module dmr_mode_regs (
   input  wire        sys_clk_in,
   input  wire        rst_n_in,
   input  wire        clk_en_in,
   input  wire        mrw_in,
   input  wire        mrr_in,
   input  wire [5:0]  addr_in,
   input  wire [7:0]  wdata_in,
   input  wire        mpc_in,
   input  wire [6:0]  mpc_op_in,
   input  wire        term_pad_in,
   input  wire [2:0]  act_code_in,
   input  wire        act_unlim_in,
   input  wire [7:0]  repair_in,
   output reg  [7:0]  rdata_out,
   output reg         rvalid_out,
   output reg  [2:0]  ctrl_term_value_out,
   output reg         ck_term_out,
   output reg         cs_term_out,
   output reg         ca_term_out,
   output reg  [2:0]  ca_term_value_out,
   output reg         trr_enable_out,
   output reg  [2:0]  trr_bank_out,
   output reg         osc_running_out
);
   reg  [7:0]  term_sp0_q;
   reg  [7:0]  term_sp1_q;
   reg  [7:0]  caval_sp0_q;
   reg  [7:0]  caval_sp1_q;
   reg  [7:0]  setpt_q;
   reg  [7:0]  runtime_q;
   reg  [3:0]  trr_q;
   reg  [2:0]  act_code_q;
   reg         act_unlim_q;
   reg  [7:0]  repair_q;
   reg         pad_s1_q;
   reg         pad_s2_q;
   reg  [7:0]  act_field;
   reg  [7:0]  term_act;
   reg  [7:0]  caval_act;
   reg  [7:0]  rd_d;
   wire        wr_sp1;
   wire        op_sp1;
   wire        caval_ok;
   wire        osc_start;
   wire        osc_stop;
   wire        osc_run;
   wire [15:0] osc_count;

   assign wr_sp1    = setpt_q[`DMR_SETPT_WR_BIT];
   assign op_sp1    = setpt_q[`DMR_SETPT_OP_BIT];
   assign osc_start = mpc_in && mpc_op_in == `DMR_OP_START_OSC;
   assign osc_stop  = mpc_in && mpc_op_in == `DMR_OP_STOP_OSC;

   // Pad level arrives from the board, so two flip-flops come first.
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pad_s1_q <= 1'b0;
         pad_s2_q <= 1'b0;
      end else if (clk_en_in) begin
         pad_s1_q <= term_pad_in;
         pad_s2_q <= pad_s1_q;
      end
   end

   // Mode register writes; each termination bit has one copy per set point.
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         term_sp0_q  <= `DMR_ZERO8;
         term_sp1_q  <= `DMR_ZERO8;
         caval_sp0_q <= `DMR_ZERO8;
         caval_sp1_q <= `DMR_ZERO8;
         setpt_q     <= `DMR_ZERO8;
         runtime_q   <= `DMR_ZERO8;
         trr_q       <= 4'h0;
      end else if (clk_en_in && mrw_in) begin
         case (addr_in)
            `DMR_ADDR_TERM: begin
               if (wr_sp1)
                  term_sp1_q <= wdata_in;
               else
                  term_sp0_q <= wdata_in;
            end
            `DMR_ADDR_CA_TERM: begin
               if (wr_sp1)
                  caval_sp1_q <= wdata_in;
               else
                  caval_sp0_q <= wdata_in;
            end
            `DMR_ADDR_SETPT:   setpt_q   <= wdata_in;
            `DMR_ADDR_RUNTIME: runtime_q <= wdata_in;
            `DMR_ADDR_ACT:     trr_q     <= wdata_in[`DMR_TRR_EN_BIT:`DMR_TRR_BANK_LSB];
            default: begin
            end
         endcase
      end
   end

   // Read-only reports sampled from their factory straps after reset release.
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         act_code_q  <= `DMR_ACT_CODE_DEF;
         act_unlim_q <= `DMR_ACT_UNLIM_DEF;
         repair_q    <= `DMR_REPAIR_DEF;
      end else if (clk_en_in) begin
         act_code_q  <= act_code_in;
         act_unlim_q <= act_unlim_in;
         repair_q    <= repair_in;
      end
   end

   // Activation field: unlimited forces the count bits to zero.
   always @* begin
      act_field = {trr_q, act_unlim_q, act_unlim_q ? `DMR_ZERO3 : act_code_q};
   end

   // Active copies chosen by the operating set point.
   always @* begin
      term_act  = op_sp1 ? term_sp1_q : term_sp0_q;
      caval_act = op_sp1 ? caval_sp1_q : caval_sp0_q;
   end

   assign caval_ok = caval_act[`DMR_CAVAL_MSB:`DMR_CAVAL_LSB] != `DMR_CTV_OFF;

   // Read data mux; the oscillator count comes as separate low and high bytes.
   always @* begin
      case (addr_in)
         `DMR_ADDR_TERM:    rd_d = wr_sp1 ? term_sp1_q : term_sp0_q;
         `DMR_ADDR_CA_TERM: rd_d = wr_sp1 ? caval_sp1_q : caval_sp0_q;
         `DMR_ADDR_SETPT:   rd_d = setpt_q;
         `DMR_ADDR_RUNTIME: rd_d = runtime_q;
         `DMR_ADDR_ACT:     rd_d = act_field;
         `DMR_ADDR_REPAIR:  rd_d = repair_q;
         `DMR_ADDR_OSC_LO:  rd_d = osc_count[7:0];
         `DMR_ADDR_OSC_HI:  rd_d = osc_count[15:8];
         default:           rd_d = `DMR_ZERO8;
      endcase
   end

   // Registered read answer, one cycle after the read command.
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out  <= `DMR_ZERO8;
         rvalid_out <= 1'b0;
      end else if (clk_en_in) begin
         rvalid_out <= mrr_in;
         if (mrr_in)
            rdata_out <= rd_d;
      end
   end

   // Termination, refresh and timer outputs; no power state gates them, so they hold in every state.
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_term_value_out <= `DMR_CTV_OFF;
         ck_term_out         <= 1'b0;
         cs_term_out         <= 1'b0;
         ca_term_out         <= 1'b0;
         ca_term_value_out   <= `DMR_CTV_OFF;
         trr_enable_out      <= 1'b0;
         trr_bank_out        <= `DMR_ZERO3;
         osc_running_out     <= 1'b0;
      end else if (clk_en_in) begin
         // Reserved divisor code is treated as off.
         ctrl_term_value_out <= (term_act[2:0] == `DMR_CTV_RESERVED) ? `DMR_CTV_OFF : term_act[2:0];
         ca_term_value_out   <= caval_act[`DMR_CAVAL_MSB:`DMR_CAVAL_LSB];
         ck_term_out <= caval_ok && (term_act[`DMR_CK_OVR_BIT] || pad_s2_q);
         cs_term_out <= caval_ok && (term_act[`DMR_CS_OVR_BIT] || pad_s2_q);
         ca_term_out <= caval_ok && pad_s2_q && !term_act[`DMR_CA_DIS_BIT];
         trr_enable_out  <= trr_q[3];
         trr_bank_out    <= trr_q[2:0];
         osc_running_out <= osc_run;
      end
   end

   // Interval timer; the start command also clears the accumulated count.
   dmr_osc_timer u_timer (
      .sys_clk_in  (sys_clk_in),
      .rst_n_in    (rst_n_in),
      .clk_en_in   (clk_en_in),
      .runtime_in  (runtime_q),
      .start_in    (osc_start),
      .stop_in     (osc_stop),
      .running_out (osc_run),
      .count_out   (osc_count)
   );
endmodule // dmr_mode_regs

/* rtl/dmr_consts.vh */
// Constants for the mode register group: addresses, field positions, defaults, timer lengths.
// Assumes inclusion by bare name from the design files.
`ifndef DMR_CONSTS_VH
`define DMR_CONSTS_VH
`define DMR_ADDR_TERM      6'h16
`define DMR_ADDR_RUNTIME   6'h17
`define DMR_ADDR_ACT       6'h18
`define DMR_ADDR_REPAIR    6'h19
`define DMR_ADDR_OSC_LO    6'h12
`define DMR_ADDR_OSC_HI    6'h13
`define DMR_ADDR_CA_TERM   6'h0B
`define DMR_ADDR_SETPT     6'h0D
`define DMR_SETPT_WR_BIT   6
`define DMR_SETPT_OP_BIT   7
`define DMR_CTV_RESERVED   3'h7
`define DMR_CTV_OFF        3'h0
`define DMR_CK_OVR_BIT     3
`define DMR_CS_OVR_BIT     4
`define DMR_CA_DIS_BIT     5
`define DMR_BYTE_DIS_LSB   6
`define DMR_BYTE_DIS_MSB   7
`define DMR_CAVAL_LSB      4
`define DMR_CAVAL_MSB      6
`define DMR_TRR_EN_BIT     7
`define DMR_TRR_BANK_LSB   4
`define DMR_TRR_BANK_MSB   6
`define DMR_ZERO8          8'h00
`define DMR_ZERO3          3'h0
`define DMR_ZERO14         14'h0000
`define DMR_ONE14          14'h0001
`define DMR_ZERO16         16'h0000
`define DMR_ONE16          16'h0001
`define DMR_RT_LONG_MIN    8'h40
`define DMR_RT_2K_MAX      8'h7F
`define DMR_RT_4K_MAX      8'hBF
`define DMR_TICKS_2K       14'h0800
`define DMR_TICKS_4K       14'h1000
`define DMR_TICKS_8K       14'h2000
`define DMR_RT_SHIFT       4
`define DMR_OP_START_OSC   7'h4B
`define DMR_OP_STOP_OSC    7'h4D
`define DMR_ACT_CODE_DEF   3'h0
`define DMR_ACT_UNLIM_DEF  1'b0
`define DMR_REPAIR_DEF     8'h00
`endif

/* rtl/dmr_osc_timer.v */
// DQS interval timer: counts clocks from start until a stop command or an automatic stop.
// Assumes start and stop are one-cycle pulses from the command decoder on the same clock.
`timescale 1ns/1ps
`include "dmr_consts.vh"
module dmr_osc_timer (
   input  wire        sys_clk_in,
   input  wire        rst_n_in,
   input  wire        clk_en_in,
   input  wire [7:0]  runtime_in,
   input  wire        start_in,
   input  wire        stop_in,
   output reg         running_out,
   output reg  [15:0] count_out
);
   reg  [13:0] limit;
   reg  [13:0] ticks_q;

   // Stop length in clocks, zero meaning run until told to stop.
   always @* begin
      if (runtime_in >= `DMR_RT_LONG_MIN) begin
         if (runtime_in <= `DMR_RT_2K_MAX)
            limit = `DMR_TICKS_2K;
         else if (runtime_in <= `DMR_RT_4K_MAX)
            limit = `DMR_TICKS_4K;
         else
            limit = `DMR_TICKS_8K;
      end else begin
         // Short codes sit below the long threshold, so the widened code times sixteen never overflows.
         limit = {6'b000000, runtime_in} << `DMR_RT_SHIFT;
      end
   end

   // Start clears the count; a stop only counts while in manual mode.
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         running_out <= 1'b0;
         ticks_q     <= `DMR_ZERO14;
         count_out   <= `DMR_ZERO16;
      end else if (clk_en_in) begin
         if (start_in) begin
            running_out <= 1'b1;
            ticks_q     <= `DMR_ZERO14;
            count_out   <= `DMR_ZERO16;
         end else if (running_out) begin
            ticks_q   <= ticks_q + `DMR_ONE14;
            count_out <= count_out + `DMR_ONE16;
            if (stop_in && limit == `DMR_ZERO14)
               running_out <= 1'b0;
            else if (limit != `DMR_ZERO14 && ticks_q + `DMR_ONE14 == limit)
               running_out <= 1'b0;
         end
      end
   end
endmodule // dmr_osc_timer

/* testbench/dmr_mode_regs_sva.sv */
// Checker for the mode register group; it sees only the top module's ports.
// Assumes one clock domain and a bind onto every instance of the group.
`timescale 1ns/1ps
module dmr_mode_regs_sva (
   input wire       sys_clk_in,
   input wire       rst_n_in,
   input wire       clk_en_in,
   input wire       mrw_in,
   input wire       mrr_in,
   input wire       mpc_in,
   input wire [5:0] addr_in,
   input wire [7:0] wdata_in,
   input wire [7:0] repair_in,
   input wire [7:0] rdata_out,
   input wire [6:0] mpc_op_in,
   input wire       rvalid_out,
   input wire       ck_term_out,
   input wire       cs_term_out,
   input wire       ca_term_out,
   input wire       trr_enable_out,
   input wire       osc_running_out,
   input wire [2:0] ctrl_term_value_out,
   input wire [2:0] ca_term_value_out,
   input wire [2:0] trr_bank_out
);
   reg [7:0] rt_q;
   // Mirrors the run-time register so that automatic stops can be timed.
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         rt_q <= 8'h00;
      else if (clk_en_in && mrw_in && addr_in == 6'h17)
         rt_q <= wdata_in;
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_read(a);
      clk_en_in && mrr_in && addr_in == a;
   endsequence
   sequence s_start16;
      clk_en_in && mpc_in && mpc_op_in == 7'h4B && rt_q == 8'h01;
   endsequence
   sequence s_run16;
      osc_running_out ##15 osc_running_out ##1 !osc_running_out;
   endsequence
   // Read answers, termination outputs, refresh control and timer stops.
   a_read_valid: assert property (clk_en_in && mrr_in |=> rvalid_out)
      else $error("read not answered");
   a_ctrl_legal: assert property (ctrl_term_value_out != 3'h7)
      else $error("reserved controller value driven");
   a_ca_needs_value: assert property (ca_term_out |-> ca_term_value_out != 3'h0)
      else $error("command termination without value");
   a_ckcs_needs_value: assert property ((ck_term_out || cs_term_out) |-> ca_term_value_out != 3'h0)
      else $error("clock or select termination without value");
   a_trr_write: assert property (clk_en_in && mrw_in && addr_in == 6'h18 |->
      ##2 {trr_enable_out, trr_bank_out, 4'h0} == ($past(wdata_in, 2) & 8'hF0))
      else $error("refresh control not taken");
   a_auto_stop16: assert property (s_start16 |-> ##2 s_run16)
      else $error("timer run length wrong");
   a_stop_halts: assert property (clk_en_in && mpc_in && mpc_op_in == 7'h4D && rt_q == 8'h00
      |-> ##2 !osc_running_out)
      else $error("timer kept running after stop");
   a_repair_read: assert property (s_read(6'h19) |=> rdata_out == $past(repair_in, 2))
      else $error("repair bits read wrong");
   a_unlim_zero: assert property (s_read(6'h18) |=> !rdata_out[3] || rdata_out[2:0] == 3'h0)
      else $error("count field not zero when unlimited");
   // A low clock enable must leave the read answer, refresh control, timer flag and clock termination where they were.
   a_freeze_hold: assert property (!clk_en_in |=>
      $stable({rvalid_out, rdata_out, trr_enable_out, trr_bank_out, osc_running_out, ck_term_out}))
      else $error("state moved while clock enable low");
endmodule // dmr_mode_regs_sva
bind dmr_mode_regs dmr_mode_regs_sva u_sva (.sys_clk_in, .rst_n_in, .clk_en_in, .mrw_in, .mrr_in, .mpc_in,
   .addr_in, .wdata_in, .repair_in, .rdata_out, .mpc_op_in, .rvalid_out, .ck_term_out, .cs_term_out,
   .ca_term_out, .trr_enable_out, .osc_running_out, .ctrl_term_value_out, .ca_term_value_out, .trr_bank_out);

/* testbench/dmr_ctl_model.sv */
// Controller model: issues mode-register write, read and multipurpose commands.
// Assumes the bench calls its task from one process on the DRAM clock.
`timescale 1ns/1ps
module dmr_ctl_model (
   input  wire       sys_clk_in,
   output reg        mrw_out, mrr_out, mpc_out,
   output reg  [5:0] addr_out,
   output reg  [7:0] wdata_out,
   output reg  [6:0] op_out
);
   reg [7:0] rt_q;
   // Starts with an idle bus.
   initial begin
      {mrw_out, mrr_out, mpc_out, addr_out, wdata_out, op_out, rt_q} = 0;
   end
   // Sends one command for one cycle, then scrambles the idle bus.
   task cmd(input [1:0] k, input [5:0] a, input [7:0] d);
      begin
         @(posedge sys_clk_in);
         if (k == 2'd0 && a == 6'h17)
            rt_q = d;
         mrw_out <= (k == 2'd0);
         mrr_out <= (k == 2'd1);
         mpc_out <= (k == 2'd2) && !(d[6:0] == 7'h4D && rt_q != 8'h00);
         addr_out <= a;
         wdata_out <= (a == 6'h16) ? (d & 8'h3F) : d;
         op_out <= d[6:0];
         @(posedge sys_clk_in);
         {mrw_out, mrr_out, mpc_out} <= 3'h0;
         addr_out <= ~a;
         wdata_out <= ~d;
      end
   endtask
endmodule // dmr_ctl_model

/* testbench/dmr_mode_regs_tb_top.sv */
// Testbench for the mode register group: a controller model sends commands, a monitor checks reads.
// Assumes a 200 MHz clock and that straps and the pad are driven here.
`timescale 1ns/1ps
module dmr_mode_regs_tb_top;
   reg          sys_clk_in, rst_n_in, clk_en_in, term_pad_in, act_unlim_in;
   reg  [2:0]   act_code_in, bank;
   reg  [7:0]   repair_in, code, exp_q [$];
   reg  [15:0]  want;
   integer      n_mismatch = 0, checked = 0, cyc = 0, seed, i, k, n;
   wire         mrw, mrr, mpc, rvalid_out, ck_t, cs_t, ca_t, trr_enable_out, osc_running_out;
   wire [5:0]   addr;
   wire [6:0]   op;
   wire [7:0]   wdata, rdata_out;
   wire [2:0]   ctv, cav, trr_bank_out;
   wire [8:0]   term_w = {ctv, ck_t, cs_t, ca_t, cav};
   localparam [47:0] CODES = 48'hC080_403F_0301;
   dmr_ctl_model ctl (.sys_clk_in(sys_clk_in), .mrw_out(mrw), .mrr_out(mrr), .mpc_out(mpc),
      .addr_out(addr), .wdata_out(wdata), .op_out(op));
   dmr_mode_regs dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .mrw_in(mrw),
      .mrr_in(mrr), .addr_in(addr), .wdata_in(wdata), .mpc_in(mpc), .mpc_op_in(op),
      .term_pad_in(term_pad_in), .act_code_in(act_code_in), .act_unlim_in(act_unlim_in),
      .repair_in(repair_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .ctrl_term_value_out(ctv),
      .ck_term_out(ck_t), .cs_term_out(cs_t), .ca_term_out(ca_t), .ca_term_value_out(cav),
      .trr_enable_out(trr_enable_out), .trr_bank_out(trr_bank_out), .osc_running_out(osc_running_out));
   task check(input [15:0] seen, input [15:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task summarize;
      begin
         if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   task settle;
      begin
         repeat (4) @(posedge sys_clk_in);
         #1;
      end
   endtask
   task wr(input [5:0] a, input [7:0] d);
      ctl.cmd(2'd0, a, d);
   endtask
   task rd(input [5:0] a, input [7:0] e);
      begin
         exp_q.push_back(e);
         ctl.cmd(2'd1, a, 8'h00);
      end
   endtask
   // Makes the clock, and ends a hung run.
   initial begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         n_mismatch = n_mismatch + 1;
         summarize;
      end
   end
   // Takes the oldest noted read result whenever the design answers.
   always @(posedge sys_clk_in) begin
      #1;
      if (rvalid_out === 1'b1)
         check(rdata_out, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx);
   end
   // Main sequence: defaults, straps, termination set points, timer.
   initial begin
      seed = $urandom(67373);
      {rst_n_in, term_pad_in, act_unlim_in, act_code_in, repair_in} = 0;
      clk_en_in = 1'b1;
      repeat (20) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      settle;
      check(term_w, 9'h000);
      check(trr_enable_out, 1'b0);
      rd(6'h16, 8'h00);
      @(posedge sys_clk_in);
      repair_in <= 8'($urandom);
      act_code_in <= 3'($urandom % 6) + 3'h1;
      bank = 3'($urandom);
      settle;
      rd(6'h19, repair_in);
      wr(6'h19, ~repair_in);
      rd(6'h19, repair_in);
      rd(6'h18, {5'h00, act_code_in});
      rd(6'h3E, 8'h00);
      @(posedge sys_clk_in);
      act_unlim_in <= 1'b1;
      settle;
      rd(6'h18, 8'h08);
      wr(6'h18, {1'b1, bank, 4'hF});
      settle;
      check({trr_enable_out, trr_bank_out}, {1'b1, bank});
      rd(6'h18, {1'b1, bank, 4'h8});
      // A low clock enable must swallow a write and a read; a stray answer meets an empty queue.
      @(posedge sys_clk_in);
      clk_en_in <= 1'b0;
      wr(6'h18, 8'h00);
      ctl.cmd(2'd1, 6'h18, 8'h00);
      @(posedge sys_clk_in);
      clk_en_in <= 1'b1;
      settle;
      check({trr_enable_out, trr_bank_out}, {1'b1, bank});
      wr(6'h0B, 8'h30);
      wr(6'h16, 8'h1D);
      settle;
      check(term_w, 9'h173);
      @(posedge sys_clk_in);
      term_pad_in <= 1'b1;
      settle;
      check(term_w, 9'h17B);
      wr(6'h16, 8'h27);
      settle;
      check(term_w, 9'h033);
      wr(6'h0D, 8'h40);
      wr(6'h16, 8'h02);
      settle;
      check(term_w, 9'h033);
      rd(6'h16, 8'h02);
      wr(6'h0D, 8'h00);
      rd(6'h16, 8'h27);
      wr(6'h0D, 8'hC0);
      settle;
      check(term_w, 9'h080);
      for (k = 0; k < 7; k = k + 1) begin
         code = (k == 6) ? 8'($urandom % 63) + 8'h01 : CODES[8*k +: 8];
         want = code < 8'h40 ? {4'h0, code, 4'h0} : code < 8'h80 ? 16'h0800 : code < 8'hC0 ? 16'h1000 : 16'h2000;
         wr(6'h17, code);
         ctl.cmd(2'd2, 6'h00, 8'h4B);
         n = 0;
         for (i = 0; i < 9000 && (n == 0 || osc_running_out); i = i + 1) begin
            @(posedge sys_clk_in);
            #1 if (osc_running_out === 1'b1) n = n + 1;
         end
         check(n[15:0], want);
         rd(6'h12, want[7:0]);
         rd(6'h13, want[15:8]);
      end
      wr(6'h17, 8'h00);
      ctl.cmd(2'd2, 6'h00, 8'h4B);
      repeat (40) @(posedge sys_clk_in);
      #1 check(osc_running_out, 1'b1);
      ctl.cmd(2'd2, 6'h00, 8'h4D);
      settle;
      check(osc_running_out, 1'b0);
      check(exp_q.size(), 0);
      summarize;
   end
endmodule // dmr_mode_regs_tb_top
